// ===== src/spr_pkg.sv
// Constants, opcodes and state types of the sector protection map block.
// Assumes a 100 MHz system clock; every user names items with spr_pkg::.
package spr_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Self-timed cycle lengths in microseconds, plain defaults.
  localparam int MAP_ERASE_TIME_US   = 20;
  localparam int MAP_PROGRAM_TIME_US = 20;

  // Cycle lengths rounded down to whole clocks, never below one.
  localparam int MAP_ERASE_CYC_RAW   = MAP_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int MAP_PROGRAM_CYC_RAW =
    MAP_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int MAP_ERASE_CYC   = (MAP_ERASE_CYC_RAW < 1) ? 1 :
                                   MAP_ERASE_CYC_RAW;
  localparam int MAP_PROGRAM_CYC = (MAP_PROGRAM_CYC_RAW < 1) ? 1 :
                                   MAP_PROGRAM_CYC_RAW;
  localparam int TIMER_W = 12;

  // Opcode bytes of the map commands.
  localparam logic [7:0] OP_SEQ0  = 8'h3D;
  localparam logic [7:0] OP_SEQ1  = 8'h2A;
  localparam logic [7:0] OP_SEQ2  = 8'h7F;
  localparam logic [7:0] OP_ERASE = 8'hCF;
  localparam logic [7:0] OP_PROG  = 8'hFC;
  localparam logic [7:0] OP_READ  = 8'h32;

  // Map geometry and values.
  localparam int         MAP_BYTES   = 4;
  localparam logic [1:0] LAST_OPC    = 2'h3;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  // Sector zero field positions.
  localparam int S0A_HI = 7;
  localparam int S0A_LO = 6;
  localparam int S0B_HI = 5;
  localparam int S0B_LO = 4;

  // Data buffer address width.
  localparam int SRAM_AW = 9;

  // Frame decode and nonvolatile engine states.
  typedef enum logic [2:0] {
    FR_OPC, FR_PROG, FR_DUMMY, FR_READ, FR_SKIP
  } spr_frame_e;
  typedef enum logic [1:0] {NV_IDLE, NV_ERASE, NV_PROG} spr_nv_e;

endpackage

// ===== src/spr_spi_if.sv
// Link between the serial shift engine and the command controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface spr_spi_if;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       frame_end;
  logic       cs_active;
  logic [7:0] tx_byte;
  logic       tx_en;
  logic       tx_next;

  modport engine (output rx_valid, rx_byte, frame_end, cs_active, tx_next,
                  input tx_byte, tx_en);
  modport ctrl   (input rx_valid, rx_byte, frame_end, cs_active, tx_next,
                  output tx_byte, tx_en);
endinterface

// ===== src/spr_spi_shift.sv
// Serial shift engine: synchronises the pins, assembles input bytes and
// shifts output bytes. Assumes sck at most one eighth of clk.
`timescale 1ns/1ps
module spr_spi_shift (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Serial pins.
  input  wire logic cs_b,
  input  wire logic sck,
  input  wire logic si,
  output logic      so,
  output logic      so_oe_b,
  // Controller side.
  spr_spi_if.engine lnk
);

  logic       cs_m, cs_s, cs_d;
  logic       sck_m, sck_s, sck_d;
  logic       si_m, si_s;
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sr_reg;
  logic [7:0] out_sr_reg;
  logic       drive_reg;
  logic       rx_valid_reg;
  logic [7:0] rx_byte_reg;
  logic       tx_next_reg;
  wire        sck_rise  = sck_s & ~sck_d;
  wire        sck_fall  = ~sck_s & sck_d;
  wire        cs_active = ~cs_s;
  wire        byte_done = sck_rise & cs_active & (bit_cnt_reg == 3'h7);

  // Two-stage synchronisers, third stage only for edge detection.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cs_m, cs_s, cs_d}    <= 3'h7;
      {sck_m, sck_s, sck_d} <= 3'h0;
      {si_m, si_s}          <= 2'h0;
    end else begin
      {cs_m, cs_s, cs_d}    <= {cs_b, cs_m, cs_s};
      {sck_m, sck_s, sck_d} <= {sck, sck_m, sck_s};
      {si_m, si_s}          <= {si, si_m};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= 3'h0;
      rx_sr_reg   <= 7'h00;
    end else if (!cs_active) begin
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      rx_sr_reg   <= {rx_sr_reg[5:0], si_s};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Completed input byte, one pulse per byte, MSB first.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid_reg <= 1'b0;
      rx_byte_reg  <= 8'h00;
    end else begin
      rx_valid_reg <= byte_done;
      if (byte_done) begin
        rx_byte_reg <= {rx_sr_reg, si_s};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sr_reg  <= 8'h00;
      drive_reg   <= 1'b0;
      tx_next_reg <= 1'b0;
    end else if (!cs_active) begin
      drive_reg   <= 1'b0;
      tx_next_reg <= 1'b0;
    end else begin
      tx_next_reg <= sck_fall & (bit_cnt_reg == 3'h0) & lnk.tx_en;
      if (sck_fall && bit_cnt_reg == 3'h0) begin
        out_sr_reg <= lnk.tx_byte;
        drive_reg  <= lnk.tx_en;
      end else if (sck_fall) begin
        out_sr_reg <= {out_sr_reg[6:0], 1'b0};
      end
    end
  end

  // Pin and link outputs.
  assign so            = out_sr_reg[7];
  assign so_oe_b       = ~(drive_reg & cs_active);
  assign lnk.rx_valid  = rx_valid_reg;
  assign lnk.rx_byte   = rx_byte_reg;
  assign lnk.frame_end = cs_s & ~cs_d;
  assign lnk.cs_active = cs_active;
  assign lnk.tx_next   = tx_next_reg;

endmodule

// ===== src/spr_sector_protect.sv
// Sector protection map: erase, program and read over the serial port.
// Assumes a host on SPI mode 0 or 3 with sck well below clk / 8.
`timescale 1ns/1ps
module spr_sector_protect (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Serial port pins.
  input  wire logic                       cs_b,
  input  wire logic                       sck,
  input  wire logic                       si,
  output logic                            so,
  output logic                            so_oe_b,
  // Write protect pin, active low.
  input  wire logic                       wp_b,
  // Protection state and array checks.
  input  wire logic                       prot_en,
  input  wire logic                       array_req,
  input  wire logic [2:0]                 array_sector,
  output logic                            array_reject,
  output logic [4:0]                      sect_prot,
  // Status.
  output logic                            busy,
  output logic [31:0]                     map_q,
  // Data buffer write port.
  output logic                            sram_wr,
  output logic [spr_pkg::SRAM_AW-1:0]     sram_addr,
  output logic [7:0]                      sram_wdata
);

  spr_spi_if lnk ();

  spr_pkg::spr_frame_e   frame_reg;
  spr_pkg::spr_nv_e      nv_reg;
  logic [1:0]            opc_cnt_reg;
  logic                  erase_arm_reg;
  logic [1:0]            wr_ptr_reg;
  logic [1:0]            rd_ptr_reg;
  logic [3:0]            got_reg;
  logic [7:0]            stage_reg [spr_pkg::MAP_BYTES];
  logic [7:0]            map_reg   [spr_pkg::MAP_BYTES];
  logic [spr_pkg::TIMER_W-1:0] timer_reg;
  logic                  wp_m, wp_s;
  logic                  sram_wr_reg;
  logic [spr_pkg::SRAM_AW-1:0] sram_addr_reg;
  logic [7:0]            sram_wdata_reg;
  logic                  array_reject_reg;
  logic [3:0]            got_prog_reg;

  // Serial shift engine.
  spr_spi_shift u_shift (
    .clk     (clk),
    .rst_b   (rst_b),
    .cs_b    (cs_b),
    .sck     (sck),
    .si      (si),
    .so      (so),
    .so_oe_b (so_oe_b),
    .lnk     (lnk.engine)
  );

  // Write protect pin synchroniser.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_m <= 1'b1;
      wp_s <= 1'b1;
    end else begin
      wp_m <= wp_b;
      wp_s <= wp_m;
    end
  end

  // Opcode byte checks for the current position in the sequence.
  wire [7:0] rx        = lnk.rx_byte;
  wire       seq_ok    = (opc_cnt_reg == 2'h0 && rx == spr_pkg::OP_SEQ0) ||
                         (opc_cnt_reg == 2'h1 && rx == spr_pkg::OP_SEQ1) ||
                         (opc_cnt_reg == 2'h2 && rx == spr_pkg::OP_SEQ2);
  wire       last_opc  = opc_cnt_reg == spr_pkg::LAST_OPC;
  wire       first_opc = opc_cnt_reg == 2'h0;
  wire       may_modify = wp_s & (nv_reg == spr_pkg::NV_IDLE);
  wire       do_erase  = lnk.frame_end & erase_arm_reg & may_modify;
  wire       do_prog   = lnk.frame_end & (frame_reg == spr_pkg::FR_PROG) &
                         (got_reg != 4'h0) & may_modify;
  wire       timer_done = timer_reg == {spr_pkg::TIMER_W{1'b0}};

  // Command decode over the bytes of one selected frame.
  // erase opcode match
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_reg     <= spr_pkg::FR_OPC;
      opc_cnt_reg   <= 2'h0;
      erase_arm_reg <= 1'b0;
    end else if (!lnk.cs_active) begin
      frame_reg     <= spr_pkg::FR_OPC;
      opc_cnt_reg   <= 2'h0;
      erase_arm_reg <= lnk.frame_end ? 1'b0 : erase_arm_reg;
    end else if (lnk.rx_valid) begin
      opc_cnt_reg <= opc_cnt_reg + 2'h1;
      case (frame_reg)
        spr_pkg::FR_OPC: begin
          if (first_opc && rx == spr_pkg::OP_READ) begin
            frame_reg <= spr_pkg::FR_DUMMY;
          end else if (seq_ok) begin
            frame_reg <= spr_pkg::FR_OPC;
          end else if (last_opc && rx == spr_pkg::OP_ERASE) begin
            erase_arm_reg <= 1'b1;
            frame_reg     <= spr_pkg::FR_SKIP;
          end else if (last_opc && rx == spr_pkg::OP_PROG) begin
            frame_reg <= spr_pkg::FR_PROG;
          end else begin
            frame_reg <= spr_pkg::FR_SKIP;
          end
        end
        spr_pkg::FR_DUMMY: begin
          if (last_opc) begin
            frame_reg <= spr_pkg::FR_READ;
          end
        end
        spr_pkg::FR_SKIP: begin
          erase_arm_reg <= 1'b0;
        end
        default: begin
          frame_reg <= frame_reg;
        end
      endcase
    end
  end

  // Program data staging with a wrapping byte pointer.
  // pointer wraps around
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 2'h0;
      got_reg    <= 4'h0;
    end else if (!lnk.cs_active) begin
      wr_ptr_reg <= 2'h0;
      got_reg    <= lnk.frame_end ? 4'h0 : got_reg;
    end else if (lnk.rx_valid && frame_reg == spr_pkg::FR_PROG) begin
      wr_ptr_reg          <= wr_ptr_reg + 2'h1;
      got_reg[wr_ptr_reg] <= 1'b1;
    end
  end

  // Staged bytes and the data buffer writes that carry them.
  // buffer overwritten
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sram_wr_reg    <= 1'b0;
      sram_addr_reg  <= {spr_pkg::SRAM_AW{1'b0}};
      sram_wdata_reg <= 8'h00;
    end else begin
      sram_wr_reg <= lnk.rx_valid & lnk.cs_active &
                     (frame_reg == spr_pkg::FR_PROG);
      if (lnk.rx_valid && frame_reg == spr_pkg::FR_PROG) begin
        sram_addr_reg  <= {{(spr_pkg::SRAM_AW-2){1'b0}}, wr_ptr_reg};
        sram_wdata_reg <= rx;
      end
    end
  end

  // Nonvolatile engine: self-timed erase and program cycles.
  // timed erase busy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_reg    <= spr_pkg::NV_IDLE;
      timer_reg <= {spr_pkg::TIMER_W{1'b0}};
    end else begin
      case (nv_reg)
        spr_pkg::NV_IDLE: begin
          if (do_erase) begin
            nv_reg    <= spr_pkg::NV_ERASE;
            timer_reg <= spr_pkg::TIMER_W'(spr_pkg::MAP_ERASE_CYC - 1);
          end else if (do_prog) begin
            nv_reg    <= spr_pkg::NV_PROG;
            timer_reg <= spr_pkg::TIMER_W'(spr_pkg::MAP_PROGRAM_CYC - 1);
          end
        end
        default: begin
          if (timer_done) begin
            nv_reg <= spr_pkg::NV_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // Per-byte staging and map storage.
  genvar g;
  generate
    for (g = 0; g < spr_pkg::MAP_BYTES; g++) begin : g_byte
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stage_reg[g] <= spr_pkg::BYTE_RESET;
          map_reg[g]   <= spr_pkg::BYTE_RESET;
        end else begin
          if (lnk.rx_valid && lnk.cs_active &&
              frame_reg == spr_pkg::FR_PROG && wr_ptr_reg == 2'(g)) begin
            stage_reg[g] <= rx;
          end
          if (nv_reg == spr_pkg::NV_ERASE && timer_done) begin
            map_reg[g] <= spr_pkg::BYTE_ERASED;
          end else if (nv_reg == spr_pkg::NV_PROG && timer_done &&
                       got_prog_reg[g]) begin
            map_reg[g] <= map_reg[g] & stage_reg[g];
          end
        end
      end
      assign map_q[8*g +: 8] = map_reg[g];
    end
  endgenerate

  // Bytes received by the program that is now running.
  // Captured at the deselect that starts the program cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      got_prog_reg <= 4'h0;
    end else if (do_prog) begin
      got_prog_reg <= got_reg;
    end
  end

  // Read pointer advances each time a map byte starts out.
  // wrap repeats the map from byte 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_reg <= 2'h0;
    end else if (!lnk.cs_active) begin
      rd_ptr_reg <= 2'h0;
    end else if (lnk.tx_next) begin
      rd_ptr_reg <= rd_ptr_reg + 2'h1;
    end
  end

  assign lnk.tx_en   = frame_reg == spr_pkg::FR_READ;
  assign lnk.tx_byte = map_reg[rd_ptr_reg];

  // Decoded protection per sector part: 0a, 0b, 1, 2, 3.
  // sector zero fields
  wire [4:0] sel_prot = {
    map_reg[3] == spr_pkg::BYTE_ERASED,
    map_reg[2] == spr_pkg::BYTE_ERASED,
    map_reg[1] == spr_pkg::BYTE_ERASED,
    &map_reg[0][spr_pkg::S0B_HI:spr_pkg::S0B_LO],
    &map_reg[0][spr_pkg::S0A_HI:spr_pkg::S0A_LO]
  };
  wire       sector_ok = array_sector < 3'h5;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      array_reject_reg <= 1'b0;
    end else begin
      array_reject_reg <= array_req & prot_en & sector_ok &
                          sel_prot[sector_ok ? array_sector : 3'h0];
    end
  end

  // Outputs.
  assign sect_prot    = prot_en ? sel_prot : 5'h00;
  assign array_reject = array_reject_reg;
  assign busy         = nv_reg != spr_pkg::NV_IDLE;
  assign sram_wr      = sram_wr_reg;
  assign sram_addr    = sram_addr_reg;
  assign sram_wdata   = sram_wdata_reg;

endmodule

// ===== verification/spr_sector_protect_sva.sv
// Checker for the sector protection map block, bound to its top ports.
// Assumes one clock domain and the busy lengths of the package.
`timescale 1ns/1ps
module spr_sector_protect_chk (
  // Clock and reset.
  input wire logic                        clk,
  input wire logic                        rst_b,
  // Serial port pins.
  input wire logic                        cs_b,
  input wire logic                        sck,
  input wire logic                        si,
  input wire logic                        so,
  input wire logic                        so_oe_b,
  // Protection and status.
  input wire logic                        wp_b,
  input wire logic                        prot_en,
  input wire logic                        array_req,
  input wire logic [2:0]                  array_sector,
  input wire logic                        array_reject,
  input wire logic [4:0]                  sect_prot,
  input wire logic                        busy,
  input wire logic [31:0]                 map_q,
  // Data buffer.
  input wire logic                        sram_wr,
  input wire logic [spr_pkg::SRAM_AW-1:0] sram_addr,
  input wire logic [7:0]                  sram_wdata
);
  localparam int BUSY_MIN = spr_pkg::MAP_ERASE_CYC - 2;
  localparam int BUSY_MAX = spr_pkg::MAP_ERASE_CYC + 3;
  logic [11:0] busy_cnt;
  logic        hit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A request on a protected part expects a refusal.
  assign hit = array_req && (array_sector <= 3'h4) && sect_prot[array_sector];

  // Counts the cycles of the present busy period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= '0;
    end else if (busy) begin
      busy_cnt <= busy_cnt + 12'h001;
    end else begin
      busy_cnt <= '0;
    end
  end

  // Chip select held high for six cycles.
  sequence cs_idle_s;
    cs_b [*6];
  endsequence

  oe_rel_a: assert property (cs_idle_s |-> so_oe_b)
    else $error("serial output still driven after deselect");
  oe_hold_a: assert property (!so_oe_b |-> !$past(cs_b, 6))
    else $error("serial output driven outside a frame");
  s0_prot_a: assert property (
    sect_prot[1:0] == (prot_en ? {&map_q[5:4], &map_q[7:6]} : 2'b00))
    else $error("sector zero protection wrong");
  s13_prot_a: assert property (
    sect_prot[4:2] == (prot_en ?
      {&map_q[31:24], &map_q[23:16], &map_q[15:8]} : 3'b000))
    else $error("sector one to three protection wrong");
  rej_match_a: assert property (array_req |=> array_reject == $past(hit))
    else $error("array refusal does not match protection");
  rej_cause_a: assert property (array_reject |-> $past(array_req))
    else $error("array refusal without a request");
  map_hold_a: assert property (!busy |=> $stable(map_q))
    else $error("map changed outside a timed cycle");
  busy_start_a: assert property ($rose(busy) |-> cs_b && $past(cs_b, 2))
    else $error("busy started inside a frame");
  busy_len_a: assert property ($fell(busy) |->
    int'(busy_cnt) >= BUSY_MIN && int'(busy_cnt) <= BUSY_MAX)
    else $error("timed cycle length wrong");
  wr_pulse_a: assert property (
    sram_wr |-> (!cs_b && sram_addr <= 9'h003) ##1 !sram_wr)
    else $error("buffer write pulse or pointer wrong");
endmodule

bind spr_sector_protect spr_sector_protect_chk u_chk (
  .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .si(si), .so(so),
  .so_oe_b(so_oe_b), .wp_b(wp_b), .prot_en(prot_en),
  .array_req(array_req), .array_sector(array_sector),
  .array_reject(array_reject), .sect_prot(sect_prot), .busy(busy),
  .map_q(map_q), .sram_wr(sram_wr), .sram_addr(sram_addr),
  .sram_wdata(sram_wdata)
);

// ===== verification/spr_host_model.sv
// Host controller model driving the serial port in mode 0 or mode 3.
// Assumes the block clock; each serial phase lasts eight clocks.
`timescale 1ns/1ps
module spr_host_model (
  // Clock and serial clock idle level, 1 selects mode 3.
  input  wire logic clk,
  input  wire logic cpol,
  // Serial pins.
  output logic      cs_b,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_b
);
  // Idle pins: deselected, clock low.
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Waits n clock edges, then steps just off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] r;
    rx = {};
    sck = cpol;
    tick(4);
    cs_b = 1'b0;
    foreach (tx[k]) begin
      for (int i = 7; i >= 0; i--) begin
        sck = 1'b0;
        si = tx[k][i];
        tick(8);
        r[i] = so;
        sck = 1'b1;
        tick(8);
      end
      rx.push_back(r);
    end
    sck = cpol;
    tick(8);
    cs_b = 1'b1;
    si = ~si;
    tick(12);
  endtask
endmodule

// ===== verification/spr_sector_protect_tb_top.sv
// Testbench top of the sector protection map block.
// Assumes the host model on the serial pins and the checker bound in.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR t=%0t got %0h expected %0h", $time, got, exp); \
    end \
  end
module spr_sector_protect_tb_top;
  logic        clk, rst_b, cs_b, sck, si, so, so_oe_b, wp_b, prot_en;
  logic        array_req, array_reject, busy, sram_wr, cpol;
  logic [2:0]  array_sector;
  logic [4:0]  sect_prot;
  logic [31:0] map_q;
  logic [8:0]  sram_addr;
  logic [7:0]  sram_wdata;
  logic [7:0]  rx[$];
  logic [7:0]  no_data[$];
  int          mismatches;
  int          samples_checked;
  int          wr_cnt;
  int          wr_base;

  spr_host_model host (.clk(clk), .cpol(cpol), .cs_b(cs_b), .sck(sck),
    .si(si), .so(so), .so_oe_b(so_oe_b));
  spr_sector_protect dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
    .sck(sck), .si(si), .so(so), .so_oe_b(so_oe_b), .wp_b(wp_b),
    .prot_en(prot_en), .array_req(array_req), .array_sector(array_sector),
    .array_reject(array_reject), .sect_prot(sect_prot), .busy(busy),
    .map_q(map_q), .sram_wr(sram_wr), .sram_addr(sram_addr),
    .sram_wdata(sram_wdata));

  // Clock of 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts buffer writes made by the block.
  always @(posedge clk) begin
    if (sram_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Waits, bounded, for the timed cycle to finish.
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("ERROR t=%0t busy never cleared", $time);
      end_sim();
    end
  endtask

  task automatic erase();
    host.frame({spr_pkg::OP_SEQ0, spr_pkg::OP_SEQ1, spr_pkg::OP_SEQ2,
      spr_pkg::OP_ERASE}, rx);
  endtask

  // Program opcodes followed by the given data bytes.
  task automatic prog(input logic [7:0] d[$]);
    logic [7:0] f[$];
    f = {spr_pkg::OP_SEQ0, spr_pkg::OP_SEQ1, spr_pkg::OP_SEQ2,
      spr_pkg::OP_PROG};
    foreach (d[k]) begin
      f.push_back(d[k]);
    end
    host.frame(f, rx);
  endtask

  // Reads the map plus one extra byte, then checks the release.
  task automatic rd_map(input logic [31:0] exp);
    host.frame({spr_pkg::OP_READ, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00}, rx);
    for (int g = 0; g < 4; g++) begin
      `CHK(rx[g + 4], exp[8*g +: 8])
    end
    `CHK(so_oe_b, 1'b1)
  endtask

  // Requests every array part in turn and checks each refusal.
  task automatic arr_chk(input logic [4:0] exp);
    for (int s = 0; s < 5; s++) begin
      array_req = 1'b1;
      array_sector = 3'(s);
      tick(1);
      array_req = 1'b0;
      `CHK(array_reject, exp[s])
      tick(1);
    end
  endtask

  // Main sequence of tests.
  initial begin
    rst_b = 1'b0;
    cpol = 1'b0;
    wp_b = 1'b1;
    prot_en = 1'b0;
    array_req = 1'b0;
    array_sector = 3'h0;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tick(3);
    `CHK(map_q, 32'h00000000)
    rd_map(32'h00000000);
    $display("test reset done");
    wp_b = 1'b0;
    erase();
    `CHK(busy, 1'b0)
    `CHK(map_q, 32'h00000000)
    wp_b = 1'b1;
    $display("test write protect done");
    prot_en = 1'b1;
    erase();
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(map_q, 32'hFFFFFFFF)
    arr_chk(5'h1F);
    $display("test erase done");
    wr_base = wr_cnt;
    prog({8'h00, 8'hFF, 8'h00, 8'hFF, 8'hC0});
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(wr_cnt - wr_base, 5)
    `CHK(sram_addr, 9'h000)
    `CHK(sram_wdata, 8'hC0)
    `CHK(map_q, 32'hFF00FFC0)
    `CHK(sect_prot, 5'h15)
    arr_chk(5'h15);
    rd_map(32'hFF00FFC0);
    $display("test program done");
    prot_en = 1'b0;
    prog({8'h00});
    wait_idle();
    `CHK(map_q, 32'hFF00FF00)
    `CHK(sect_prot, 5'h00)
    $display("test partial program done");
    // a whole extra byte cancels the erase
    host.frame({spr_pkg::OP_SEQ0, spr_pkg::OP_SEQ1, spr_pkg::OP_SEQ2,
      spr_pkg::OP_ERASE, 8'h00}, rx);
    `CHK(busy, 1'b0)
    prog(no_data);
    `CHK(busy, 1'b0)
    `CHK(map_q, 32'hFF00FF00)
    // program refused while the erase still runs
    erase();
    `CHK(busy, 1'b1)
    prog({8'h00, 8'h00, 8'h00, 8'h00});
    wait_idle();
    `CHK(map_q, 32'hFFFFFFFF)
    $display("test refused commands done");
    // read back with the clock idling high
    cpol = 1'b1;
    rd_map(32'hFFFFFFFF);
    $display("test mode 3 read done");
    end_sim();
  end

  // Cuts a hung run short.
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("ERROR t=%0t run too long", $time);
    end_sim();
  end
endmodule
